// ---- design/cpo_can_config.sv ----
// CAN option registers, bit timing, receive stages and transmit buffer
// Operation
// - Heavy-vehicle rate is 500 over divisor
// - Option b7 picks 29 or 11-bit
// - Option b6 picks fixed eight or DLC
// - Option b5 accepts both identifier lengths
// - Option b4 multiplies bit rate by 8/7
// - First option byte resets to E0
// - First user divisor defaults to 04
// - Second option byte resets to 80
// - Second user divisor defaults to 0A
// - Error-check byte 3C, b7 length check
// - Values are raw hex, never decimal
// - Bit b7 is msb, b0 lsb
// - Rate report ignores the 8/7 multiplier
// - Two chained receive registers
// - Check, format, ASCII, queue each frame
// - 512-byte buffer, full aborts with error
//
// The Avalon-MM interface to the registers was left to the implementer.
module cpo_can_config #(
	parameter int BUF_DEPTH = cpo_pkg::BUF_DEPTH
) (
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        rx_frame_valid,
	input  wire logic        rx_ext,
	input  wire logic [28:0] rx_id,
	input  wire logic [3:0]  rx_dlc,
	input  wire logic [63:0] rx_data,
	output logic      [7:0]  tx_byte,
	output logic             tx_valid,
	input  wire logic        tx_ready,
	output logic             can_bit_tick,
	output logic             can_tx_std_id,
	output logic             can_fixed_len,
	output logic             irq
);
	localparam int PW = $clog2(BUF_DEPTH);

	// Whole module state
	typedef struct packed {
		logic [7:0]                 err_chk;  // Error checking options
		logic [7:0]                 hv_div;   // Heavy-vehicle divisor
		logic [7:0]                 u1_opt;   // First custom options
		logic [7:0]                 u1_div;   // First custom divisor
		logic [7:0]                 u2_opt;   // Second custom options
		logic [7:0]                 u2_div;   // Second custom divisor
		cpo_pkg::cpo_prot_t         prot;     // Active protocol
		logic [3:0]                 status;   // Sticky events
		logic [3:0]                 mask;     // Interrupt enables
		logic                       ack;      // Bus answer cycle
		logic [31:0]                rdata;    // Read data
		logic                       s1_full;  // First stage holds frame
		cpo_pkg::cpo_frame_t        s1;       // First stage
		logic                       s2_full;  // Second stage holds frame
		cpo_pkg::cpo_frame_t        s2;       // Second stage
		logic [PW-1:0]              wptr;     // Buffer write index
		logic [PW-1:0]              rptr;     // Buffer read index
		logic [PW:0]                count;    // Bytes queued
		logic [BUF_DEPTH-1:0][7:0]  mem;      // Transmit buffer
		logic [13:0]                bit_cnt;  // Bit period counter
		logic                       bit_tick; // Bit rate enable
	} cpo_state_t;

	cpo_state_t state_reg;
	cpo_state_t state_next;

	cpo_fmt_if fi ();

	// Frame formatter behind the second stage
	cpo_frame_fmt u_fmt (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.fi       (fi)
	);

	logic [7:0]  act_opt;   // Option byte of active protocol
	logic [7:0]  act_div;   // Divisor of active protocol
	logic        use_opt;   // Protocol uses an option byte
	logic [13:0] period;    // Cycles per CAN bit
	logic [8:0]  rate_rpt;  // Reported rate in kbps
	logic        id_ok;     // Identifier length accepted
	logic        len_ok;    // Data length check passed
	logic        buf_full;  // No room in the buffer
	logic        take_s2;   // Second stage examined this cycle
	logic        accept;    // Frame passes every check
	logic        push;      // Byte written into buffer
	logic        pop;       // Byte taken by host
	logic [5:0]  idx;       // Word index of bus access
	logic        wr_go;     // Write takes effect
	logic        div_ok;    // Written divisor in range
	logic [7:0]  wbyte;     // Low write byte

	// Active protocol parameters
	always_comb begin
		case (state_reg.prot)
			cpo_pkg::CPO_PROT_U1: begin
				act_opt = state_reg.u1_opt;
				act_div = state_reg.u1_div;
				use_opt = 1'b1;
			end
			cpo_pkg::CPO_PROT_U2: begin
				act_opt = state_reg.u2_opt;
				act_div = state_reg.u2_div;
				use_opt = 1'b1;
			end
			default: begin
				// Heavy-vehicle traffic is 29-bit, variable length
				act_opt = 8'h40;
				act_div = state_reg.hv_div;
				use_opt = 1'b0;
			end
		endcase
	end

	// Bit period: divisor times 40 cycles, or 35 with the 8/7 boost
	assign period = use_opt && act_opt[cpo_pkg::OPT_MUL87] ?
		14'(act_div * cpo_pkg::UNIT_CYC_87) :
		14'(act_div * cpo_pkg::UNIT_CYC);
	// Report uses the divisor alone, never the boost
	assign rate_rpt = 9'(cpo_pkg::BASE_KBPS / act_div);

	// Acceptance: both lengths, or only the one chosen for transmit
	assign id_ok = act_opt[cpo_pkg::OPT_RX_BOTH] ||
		(state_reg.s2.ext == !act_opt[cpo_pkg::OPT_TX_STD]);
	// ISO15765 check demands a full eight-byte frame
	assign len_ok = !state_reg.err_chk[cpo_pkg::ERR_LEN_CHK] ||
		(state_reg.s2.dlc == 4'(cpo_pkg::FULL_LEN));
	assign buf_full = (state_reg.count == (PW+1)'(BUF_DEPTH));
	assign take_s2  = state_reg.s2_full && !fi.busy;
	assign accept   = id_ok && len_ok;

	// Formatter handoff
	assign fi.frame      = state_reg.s2;
	assign fi.start      = take_s2 && accept && !buf_full;
	assign fi.var_len    = act_opt[cpo_pkg::OPT_VAR_LEN];
	assign fi.byte_ready = !buf_full;
	assign push          = fi.byte_valid && !buf_full;

	// Host side of the buffer
	assign tx_valid = (state_reg.count != '0);
	assign tx_byte  = state_reg.mem[state_reg.rptr];
	assign pop      = tx_valid && tx_ready;

	// Bus decode helpers; data is taken as the raw byte
	assign idx    = avs_address[7:2];
	assign wr_go  = avs_write && state_reg.ack && avs_byteenable[0];
	assign wbyte  = avs_writedata[7:0];
	assign div_ok = (wbyte >= cpo_pkg::DIV_MIN) &&
		(wbyte <= cpo_pkg::DIV_MAX);

	// Next state
	always_comb begin
		state_next = state_reg;

		// One wait cycle, then the answer
		state_next.ack = (avs_read || avs_write) && !state_reg.ack;

		// Read mux; field bits keep their b7..b0 order
		if (avs_read && !state_reg.ack) begin
			if (idx == cpo_pkg::IDX_ERR_CHECK) begin
				state_next.rdata = {24'h0, state_reg.err_chk};
			end else if (idx == cpo_pkg::IDX_HV_DIV) begin
				state_next.rdata = {24'h0, state_reg.hv_div};
			end else if (idx == cpo_pkg::IDX_U1_OPT) begin
				state_next.rdata = {24'h0, state_reg.u1_opt};
			end else if (idx == cpo_pkg::IDX_U1_DIV) begin
				state_next.rdata = {24'h0, state_reg.u1_div};
			end else if (idx == cpo_pkg::IDX_U2_OPT) begin
				state_next.rdata = {24'h0, state_reg.u2_opt};
			end else if (idx == cpo_pkg::IDX_U2_DIV) begin
				state_next.rdata = {24'h0, state_reg.u2_div};
			end else if (idx == cpo_pkg::IDX_PROT_SEL) begin
				state_next.rdata = {30'h0, state_reg.prot};
			end else if (idx == cpo_pkg::IDX_IRQ_STATUS) begin
				state_next.rdata = {28'h0, state_reg.status};
			end else if (idx == cpo_pkg::IDX_IRQ_MASK) begin
				state_next.rdata = {28'h0, state_reg.mask};
			end else if (idx == cpo_pkg::IDX_RATE_RPT) begin
				state_next.rdata = {23'h0, rate_rpt};
			end else if (idx == cpo_pkg::IDX_BUF_LEVEL) begin
				state_next.rdata = 32'(state_reg.count);
			end else begin
				// Unmapped reads answer zero
				state_next.rdata = 32'h0;
			end
		end

		// Register writes; out-of-range divisors are ignored
		if (wr_go) begin
			if (idx == cpo_pkg::IDX_ERR_CHECK) begin
				state_next.err_chk = wbyte;
			end else if (idx == cpo_pkg::IDX_HV_DIV && div_ok) begin
				state_next.hv_div = wbyte;
			end else if (idx == cpo_pkg::IDX_U1_OPT) begin
				// Reserved and format bits stored as given
				state_next.u1_opt = wbyte;
			end else if (idx == cpo_pkg::IDX_U1_DIV && div_ok) begin
				state_next.u1_div = wbyte;
			end else if (idx == cpo_pkg::IDX_U2_OPT) begin
				state_next.u2_opt = wbyte;
			end else if (idx == cpo_pkg::IDX_U2_DIV && div_ok) begin
				state_next.u2_div = wbyte;
			end else if (idx == cpo_pkg::IDX_PROT_SEL) begin
				// Code 3 is not a protocol, keep the old choice
				if (wbyte[1:0] != 2'h3) begin
					state_next.prot = cpo_pkg::cpo_prot_t'(wbyte[1:0]);
				end
			end else if (idx == cpo_pkg::IDX_IRQ_STATUS) begin
				state_next.status = state_reg.status & ~wbyte[3:0];
			end else if (idx == cpo_pkg::IDX_IRQ_MASK) begin
				state_next.mask = wbyte[3:0];
			end
		end

		// Bit rate divider, restarted at once if the count is already past a shrunken period
		state_next.bit_tick = 1'b0;
		if (state_reg.bit_cnt >= period - 14'h1) begin
			state_next.bit_cnt  = 14'h0;
			state_next.bit_tick = 1'b1;
		end else begin
			state_next.bit_cnt = state_reg.bit_cnt + 14'h1;
		end

		// Second stage drains into the checker
		if (take_s2) begin
			state_next.s2_full = 1'b0;
			if (!accept) begin
				state_next.status[cpo_pkg::ST_REJECT] = 1'b1;
			end else if (buf_full) begin
				state_next.status[cpo_pkg::ST_FULL] = 1'b1;
			end
		end
		// First stage passes on once the second is free
		if (state_reg.s1_full && !state_next.s2_full) begin
			state_next.s2      = state_reg.s1;
			state_next.s2_full = 1'b1;
			state_next.s1_full = 1'b0;
		end
		// Bus frame lands in the first stage, or is lost if both busy
		if (rx_frame_valid) begin
			if (!state_next.s1_full) begin
				state_next.s1      = {rx_ext, rx_id, rx_dlc, rx_data};
				state_next.s1_full = 1'b1;
			end else begin
				state_next.status[cpo_pkg::ST_OVERRUN] = 1'b1;
			end
		end

		// Formatter results; events win over a same-cycle clear
		if (fi.done) begin
			state_next.status[cpo_pkg::ST_QUEUED] = 1'b1;
		end
		if (fi.abort) begin
			state_next.status[cpo_pkg::ST_FULL] = 1'b1;
		end

		// Transmit buffer pointers
		if (push) begin
			state_next.mem[state_reg.wptr] = fi.byte_data;
			state_next.wptr = state_reg.wptr + PW'(1);
		end
		if (pop) begin
			state_next.rptr = state_reg.rptr + PW'(1);
		end
		state_next.count = state_reg.count + (PW+1)'(push) -
			(PW+1)'(pop);
	end

	// State register with documented reset values
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_reg         <= '0;
			state_reg.err_chk <= cpo_pkg::RST_ERR_CHECK;
			state_reg.hv_div  <= cpo_pkg::RST_HV_DIV;
			state_reg.u1_opt  <= cpo_pkg::RST_U1_OPT;
			state_reg.u1_div  <= cpo_pkg::RST_U1_DIV;
			state_reg.u2_opt  <= cpo_pkg::RST_U2_OPT;
			state_reg.u2_div  <= cpo_pkg::RST_U2_DIV;
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs
	assign avs_waitrequest = (avs_read || avs_write) && !state_reg.ack;
	assign avs_readdata    = state_reg.rdata;
	assign can_bit_tick    = state_reg.bit_tick;
	assign can_tx_std_id   = act_opt[cpo_pkg::OPT_TX_STD];
	assign can_fixed_len   = !act_opt[cpo_pkg::OPT_VAR_LEN];
	assign irq             = |(state_reg.status & state_reg.mask);

	// Checks
	sequence seq_reset_release;
		$past(sys_rst);
	endsequence

	AST_RESET_OPTIONS: assert property (@(posedge core_clk) disable iff (sys_rst)
		seq_reset_release |-> state_reg.u1_opt == 8'he0 &&
		state_reg.u2_opt == 8'h80 && state_reg.err_chk == 8'h3c)
		else $error("option bytes wrong after reset");
	AST_DIV_RANGE: assert property (@(posedge core_clk) disable iff (sys_rst)
		state_reg.hv_div >= 8'h01 && state_reg.hv_div <= 8'h40)
		else $error("divisor left its range");
	AST_BIT_SPACING: assert property (@(posedge core_clk) disable iff (sys_rst)
		can_bit_tick && $stable(period) |=> !can_bit_tick[*8])
		else $error("bit ticks too close");
	AST_RATE_REPORT: assert property (@(posedge core_clk) disable iff (sys_rst)
		act_div == 8'h06 |-> rate_rpt == 9'd83)
		else $error("reported rate includes the boost");
	AST_ID_FILTER: assert property (@(posedge core_clk) disable iff (sys_rst)
		take_s2 && !act_opt[5] && (state_reg.s2.ext == act_opt[7])
		|-> !fi.start ##1 state_reg.status[cpo_pkg::ST_REJECT])
		else $error("wrong identifier length accepted");
	AST_LEN_CHECK: assert property (@(posedge core_clk) disable iff (sys_rst)
		take_s2 && state_reg.err_chk[7] && state_reg.s2.dlc != 4'h8
		|-> !fi.start)
		else $error("short frame passed the length check");
	AST_STAGE_CHAIN: assert property (@(posedge core_clk) disable iff (sys_rst)
		state_reg.s1_full && !state_reg.s2_full |=> state_reg.s2_full &&
		state_reg.s2 == $past(state_reg.s1))
		else $error("first stage did not pass on");
	AST_FULL_DROP: assert property (@(posedge core_clk) disable iff (sys_rst)
		buf_full |-> !fi.start && !push)
		else $error("queued into a full buffer");
	AST_FULL_FLAG: assert property (@(posedge core_clk) disable iff (sys_rst)
		fi.abort |=> state_reg.status[cpo_pkg::ST_FULL])
		else $error("buffer full not reported");
	AST_WAIT_ONE: assert property (@(posedge core_clk) disable iff (sys_rst)
		$rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus answer not after one wait cycle");
endmodule : cpo_can_config

// ---- design/cpo_pkg.sv ----
// Constants, types and helpers shared by the CAN option configuration block
package cpo_pkg;
	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_ERR_CHECK  = 6'h2a;
	localparam logic [5:0] IDX_HV_DIV     = 6'h2b;
	localparam logic [5:0] IDX_U1_OPT     = 6'h2c;
	localparam logic [5:0] IDX_U1_DIV     = 6'h2d;
	localparam logic [5:0] IDX_U2_OPT     = 6'h2e;
	localparam logic [5:0] IDX_U2_DIV     = 6'h2f;
	localparam logic [5:0] IDX_PROT_SEL   = 6'h30;
	localparam logic [5:0] IDX_IRQ_STATUS = 6'h31;
	localparam logic [5:0] IDX_IRQ_MASK   = 6'h32;
	localparam logic [5:0] IDX_RATE_RPT   = 6'h33;
	localparam logic [5:0] IDX_BUF_LEVEL  = 6'h34;
	// Reset values
	localparam logic [7:0] RST_ERR_CHECK = 8'h3c;
	localparam logic [7:0] RST_HV_DIV    = 8'h02;
	localparam logic [7:0] RST_U1_OPT    = 8'he0;
	localparam logic [7:0] RST_U1_DIV    = 8'h04;
	localparam logic [7:0] RST_U2_OPT    = 8'h80;
	localparam logic [7:0] RST_U2_DIV    = 8'h0a;
	// Divisor range
	localparam logic [7:0] DIV_MIN = 8'h01;
	localparam logic [7:0] DIV_MAX = 8'h40;
	// Option byte fields, b7 is the msb
	localparam int OPT_TX_STD  = 7;
	localparam int OPT_VAR_LEN = 6;
	localparam int OPT_RX_BOTH = 5;
	localparam int OPT_MUL87   = 4;
	localparam int ERR_LEN_CHK = 7;
	// Interrupt status bits
	localparam int ST_QUEUED  = 0;
	localparam int ST_FULL    = 1;
	localparam int ST_REJECT  = 2;
	localparam int ST_OVERRUN = 3;
	// Timing: base rate in kbps over the divisor
	localparam int CLK_KHZ     = 20000;
	localparam int BASE_KBPS   = 500;
	localparam int UNIT_CYC    = CLK_KHZ / BASE_KBPS;
	localparam int MUL_NUM     = 8;
	localparam int MUL_DEN     = 7;
	localparam int UNIT_CYC_87 = UNIT_CYC * MUL_DEN / MUL_NUM;
	localparam int BUF_DEPTH   = 512;
	localparam int FULL_LEN    = 8;
	localparam logic [7:0] ASCII_CR = 8'h0d;
	// Selected protocol
	typedef enum logic [1:0] {
		CPO_PROT_HV,
		CPO_PROT_U1,
		CPO_PROT_U2
	} cpo_prot_t;
	// One received frame
	typedef struct packed {
		logic            ext;
		logic [28:0]     id;
		logic [3:0]      dlc;
		logic [7:0][7:0] data;
	} cpo_frame_t;
	// Nibble to upper-case ASCII hex digit
	function automatic logic [7:0] cpo_hex(input logic [3:0] v);
		cpo_hex = (v < 4'ha) ? (8'h30 + {4'h0, v}) : (8'h37 + {4'h0, v});
	endfunction : cpo_hex
endpackage : cpo_pkg

// ---- design/cpo_fmt_if.sv ----
// Handoff between the receive stages and the ASCII formatter
interface cpo_fmt_if;
	cpo_pkg::cpo_frame_t frame;      // Frame to format
	logic                start;      // One-cycle frame handoff
	logic                var_len;    // Payload follows the DLC
	logic                busy;       // Formatter working
	logic [7:0]          byte_data;  // ASCII byte to queue
	logic                byte_valid; // Byte offered
	logic                byte_ready; // Transmit buffer has room
	logic                done;       // Frame fully queued
	logic                abort;      // Buffer filled mid-frame
	modport top (output frame, start, var_len, byte_ready,
		input busy, byte_data, byte_valid, done, abort);
	modport fmt (input frame, start, var_len, byte_ready,
		output busy, byte_data, byte_valid, done, abort);
endinterface : cpo_fmt_if

// ---- design/cpo_frame_fmt.sv ----
// Formats one accepted frame as ASCII hex, one byte per cycle
module cpo_frame_fmt (
	input  wire logic core_clk,
	input  wire logic sys_rst,
	cpo_fmt_if.fmt    fi
);
	typedef enum logic [1:0] {
		CPO_F_IDLE,
		CPO_F_ID,
		CPO_F_DATA,
		CPO_F_EOL
	} cpo_fstate_t;

	typedef struct packed {
		cpo_fstate_t         st;    // Sequence state
		cpo_pkg::cpo_frame_t fr;    // Captured frame
		logic [3:0]          nib;   // Nibbles left in field
		logic [3:0]          len;   // Payload bytes to send
		logic [3:0]          idx;   // Current payload byte
		logic                done;  // Frame completed
		logic                abort; // Frame abandoned
	} cpo_fmt_state_t;

	cpo_fmt_state_t s_reg;
	cpo_fmt_state_t s_next;
	logic [31:0]    id_w; // Identifier padded to whole nibbles
	logic [7:0]     cur;  // Payload byte being sent

	assign id_w = {3'h0, s_reg.fr.id};
	assign cur  = s_reg.fr.data[s_reg.idx[2:0]];

	// Byte offered depends only on state and position
	always_comb begin
		fi.byte_valid = (s_reg.st != CPO_F_IDLE);
		case (s_reg.st)
			CPO_F_ID:   fi.byte_data = cpo_pkg::cpo_hex(id_w[s_reg.nib*4 +: 4]);
			CPO_F_DATA: fi.byte_data = cpo_pkg::cpo_hex(s_reg.nib[0] ?
				cur[7:4] : cur[3:0]);
			CPO_F_EOL:  fi.byte_data = cpo_pkg::ASCII_CR;
			default:    fi.byte_data = 8'h00;
		endcase
	end
	assign fi.busy  = (s_reg.st != CPO_F_IDLE);
	assign fi.done  = s_reg.done;
	assign fi.abort = s_reg.abort;

	// Sequencer: identifier digits, payload digits, carriage return
	always_comb begin
		s_next       = s_reg;
		s_next.done  = 1'b0;
		s_next.abort = 1'b0;
		case (s_reg.st)
			CPO_F_IDLE: begin
				if (fi.start) begin
					s_next.fr  = fi.frame;
					s_next.st  = CPO_F_ID;
					s_next.nib = fi.frame.ext ? 4'h7 : 4'h2;
					s_next.idx = 4'h0;
					// Fixed mode always sends eight bytes
					s_next.len = !fi.var_len ? 4'(cpo_pkg::FULL_LEN) :
						(fi.frame.dlc > 4'h8) ? 4'h8 : fi.frame.dlc;
				end
			end
			default: begin
				if (!fi.byte_ready) begin
					// Buffer full: drop the rest of this frame
					s_next.st    = CPO_F_IDLE;
					s_next.abort = 1'b1;
				end else if (s_reg.st == CPO_F_EOL) begin
					s_next.st   = CPO_F_IDLE;
					s_next.done = 1'b1;
				end else if (s_reg.nib != 4'h0) begin
					s_next.nib = s_reg.nib - 4'h1;
				end else if (s_reg.st == CPO_F_ID) begin
					s_next.st  = (s_reg.len == 4'h0) ? CPO_F_EOL : CPO_F_DATA;
					s_next.nib = 4'h1;
				end else if (s_reg.idx + 4'h1 == s_reg.len) begin
					s_next.st = CPO_F_EOL;
				end else begin
					s_next.idx = s_reg.idx + 4'h1;
					s_next.nib = 4'h1;
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	AST_ABORT_ON_FULL: assert property (@(posedge core_clk) disable iff (sys_rst)
		fi.byte_valid && !fi.byte_ready |=> fi.abort && !fi.busy)
		else $error("formatter kept going into a full buffer");
endmodule : cpo_frame_fmt

// ---- testbench/cpo_far_model.sv ----
// Host model that takes queued ASCII bytes, promptly or with stalls
module cpo_far_model (
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	input  wire logic [7:0] tx_byte,
	input  wire logic       tx_valid,
	output logic            tx_ready,
	input  wire logic       stall
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] got[$]; // Bytes taken, in order
	// Ready drops at random so the queue sees back-pressure
	always @(posedge core_clk) begin
		if (!sys_rst && tx_valid && tx_ready)
			got.push_back(tx_byte);
		if (sys_rst)
			tx_ready <= 1'b0;
		else
			tx_ready <= !stall && ($urandom_range(3) != 0);
	end
endmodule : cpo_far_model

// ---- testbench/test_cpo_can_config.sv ----
// Self-checking bench for the CAN option configuration block
module test_cpo_can_config;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LIM = 6000; // Bound on the tick_gap, drain and quiet waits
	logic        core_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'h1;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest, tx_valid, tx_ready, irq;
	logic        rx_frame_valid = 1'b0;
	logic        rx_ext = 1'b0;
	logic [28:0] rx_id = 29'h0;
	logic [3:0]  rx_dlc = 4'h0;
	logic [63:0] rx_data = 64'h0;
	logic [7:0]  tx_byte, d;
	logic        can_bit_tick, can_tx_std_id, can_fixed_len;
	logic        stall = 1'b0; // Host holds off
	int          err_count = 0;
	int          total_checks = 0;
	int          g;
	logic [63:0] r;
	logic [7:0]  exp_q[$]; // Expected host bytes
	logic [7:0]  rv[6] = '{8'h3c, 8'h02, 8'he0, 8'h04, 8'h80, 8'h0a};
	// 20 MHz clock
	always #25 core_clk = ~core_clk;
	// Small queue so that filling it stays cheap
	cpo_can_config #(.BUF_DEPTH(32)) i_dut (.*);
	cpo_far_model i_far (.*);
	task automatic stop_test();
		if (err_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test
	task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic guard(int n, int lim);
		if (n >= lim) begin
			err_count++;
			stop_test();
		end
	endtask : guard
	// One bus transfer; waitrequest is judged at the rising edge
	task automatic bus(logic w, logic [5:0] ix, logic [7:0] v,
		output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge core_clk);
		avs_address <= {ix, 2'b00};
		avs_writedata <= {24'h0, v};
		avs_write <= w;
		avs_read <= ~w;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		guard(n, 20);
		// Answer edge: take the data and release in the same step
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	task automatic wr(logic [5:0] ix, logic [7:0] v);
		logic [31:0] x;
		bus(1'b1, ix, v, x);
	endtask : wr
	task automatic rchk(logic [5:0] ix, logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, ix, 8'h00, x);
		chk($sformatf("reg %h", ix), e, x);
	endtask : rchk
	task automatic wait_st(logic [7:0] m);
		logic [31:0] v;
		int n;
		n = 0;
		v = 8'h00;
		while ((v & m) == 8'h00 && n < 50) begin
			bus(1'b0, 6'h31, 8'h00, v);
			n++;
		end
		guard(n, 50);
	endtask : wait_st
	// Cycles from one bit tick to the next
	task automatic tick_gap(output int gp);
		int n;
		n = 0;
		gp = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (can_bit_tick !== 1'b1 && n < LIM);
		do begin
			@(posedge core_clk);
			gp++;
		end while (can_bit_tick !== 1'b1 && gp < LIM);
		guard(n, LIM);
	endtask : tick_gap
	function automatic logic [7:0] hx(logic [3:0] v);
		return (v < 4'ha) ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
	endfunction : hx
	// Id digits msb first, two digits per byte, then carriage return
	function automatic void add_exp(logic e, logic [28:0] id,
		logic [3:0] n, logic [63:0] dt, logic fix);
		int k;
		logic [31:0] w;
		k = fix ? 8 : ((n > 4'h8) ? 8 : int'(n));
		w = {3'b000, id};
		for (int i = (e ? 7 : 2); i >= 0; i--)
			exp_q.push_back(hx(w[4*i +: 4]));
		for (int i = 0; i < k; i++) begin
			exp_q.push_back(hx(dt[8*i+4 +: 4]));
			exp_q.push_back(hx(dt[8*i +: 4]));
		end
		exp_q.push_back(8'h0d);
	endfunction : add_exp
	task automatic put(logic e, logic [28:0] id, logic [3:0] n,
		logic [63:0] dt, logic ok, logic fix);
		rx_frame_valid <= 1'b1;
		rx_ext <= e;
		rx_id <= id;
		rx_dlc <= n;
		rx_data <= dt;
		if (ok)
			add_exp(e, id, n, dt, fix);
		@(posedge core_clk);
	endtask : put
	task automatic send(logic e, logic [28:0] id, logic [3:0] n,
		logic [63:0] dt, logic ok, logic fix);
		put(e, id, n, dt, ok, fix);
		rx_frame_valid <= 1'b0;
		@(posedge core_clk);
	endtask : send
	// Frames on consecutive cycles
	task automatic burst(int k, logic ok);
		for (int i = 0; i < k; i++)
			put(1'b0, 29'(i + 1), 4'h0, 64'h0, ok, 1'b0);
		rx_frame_valid <= 1'b0;
		@(posedge core_clk);
	endtask : burst
	task automatic drain();
		int n;
		n = 0;
		while (i_far.got.size() < exp_q.size() && n < LIM) begin
			@(posedge core_clk);
			n++;
		end
		guard(n, LIM);
		chk("byte count", exp_q.size(), i_far.got.size());
		foreach (exp_q[i])
			chk("tx_byte", exp_q[i], i_far.got[i]);
		exp_q.delete();
		i_far.got.delete();
	endtask : drain
	// Waits until the queue has stayed empty for a while
	task automatic quiet();
		int n, q;
		n = 0;
		q = 0;
		while (q < 20 && n < LIM) begin
			@(negedge core_clk);
			q = (tx_valid === 1'b0) ? q + 1 : 0;
			n++;
		end
		guard(n, LIM);
		i_far.got.delete();
	endtask : quiet
	initial begin
		void'($urandom(32'h481f));
		repeat (10) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		for (int i = 0; i < 6; i++)
			rchk(6'h2a + 6'(i), rv[i]);
		rchk(6'h3f, 8'h00);
		rchk(6'h33, 8'd250);
		wr(6'h2b, 8'h41);
		wr(6'h2b, 8'h00);
		rchk(6'h2b, 8'h02);
		wr(6'h2b, 8'h40);
		rchk(6'h33, 8'd7);
		avs_byteenable <= 4'h0;
		wr(6'h2b, 8'h10);
		avs_byteenable <= 4'h1;
		rchk(6'h2b, 8'h40);
		wr(6'h30, 8'h02);
		wr(6'h30, 8'h03);
		rchk(6'h30, 8'h02);
		rchk(6'h33, 8'd50);
		chk("std id", 1, can_tx_std_id);
		chk("fixed len", 1, can_fixed_len);
		wr(6'h30, 8'h01);
		wr(6'h2c, 8'h90);
		for (int i = 0; i < 6; i++) begin
			d = 8'($urandom_range(1, 64));
			wr(6'h2d, d);
			rchk(6'h33, 32'(500 / d));
		end
		wr(6'h2d, 8'h06);
		rchk(6'h33, 8'd83);
		wr(6'h2d, 8'h01);
		wr(6'h2a, 8'h00);
		tick_gap(g);
		chk("bit period", 35, g);
		chk("std id", 1, can_tx_std_id);
		chk("fixed len", 1, can_fixed_len);
		r = {$urandom, $urandom};
		send(1'b0, 29'h7e8, 4'h3, r, 1'b1, 1'b1);
		send(1'b1, 29'h18daf110, 4'h8, r, 1'b0, 1'b1);
		drain();
		rchk(6'h31, 8'h05);
		wr(6'h31, 8'h0f);
		rchk(6'h31, 8'h00);
		wr(6'h2c, 8'h40);
		tick_gap(g);
		chk("bit period", 40, g);
		chk("std id", 0, can_tx_std_id);
		chk("fixed len", 0, can_fixed_len);
		send(1'b1, 29'h18daf110, 4'h2, r, 1'b1, 1'b0);
		send(1'b0, 29'h7df, 4'h1, r, 1'b0, 1'b0);
		drain();
		wr(6'h2c, 8'h60);
		send(1'b0, 29'h7df, 4'hf, r, 1'b1, 1'b0);
		burst(2, 1'b1);
		drain();
		rchk(6'h31, 8'h05);
		burst(6, 1'b0);
		wait_st(8'h08);
		quiet();
		wr(6'h31, 8'h0f);
		wr(6'h2a, 8'h80);
		send(1'b0, 29'h7e0, 4'h2, r, 1'b0, 1'b0);
		send(1'b0, 29'h7e0, 4'h8, r, 1'b1, 1'b0);
		drain();
		rchk(6'h31, 8'h05);
		wr(6'h2a, 8'h00);
		wr(6'h31, 8'h0f);
		stall <= 1'b1;
		send(1'b0, 29'h123, 4'h8, r, 1'b1, 1'b0);
		send(1'b1, 29'h1abcdef, 4'h8, r, 1'b1, 1'b0);
		repeat (13) void'(exp_q.pop_back());
		send(1'b0, 29'h456, 4'h8, r, 1'b0, 1'b0);
		wait_st(8'h02);
		rchk(6'h34, 8'd32);
		@(negedge core_clk);
		chk("irq", 0, irq);
		wr(6'h32, 8'h02);
		@(negedge core_clk);
		chk("irq", 1, irq);
		wr(6'h31, 8'h0f);
		stall <= 1'b0;
		drain();
		@(negedge core_clk);
		chk("irq", 0, irq);
		stop_test();
	end
endmodule : test_cpo_can_config
